// [src/dtss_pkg.sv]
// shared constants and types for the drum track select and status block
package dtss_pkg;
  // ****************************************
  // drum geometry
  // ****************************************
  localparam int unsigned N_TRACKS    = 384;
  localparam int unsigned ADDR_W      = 9;
  localparam int unsigned TRACK_WORDS = 1024;
  localparam int unsigned DATA_BITS   = 30;
  localparam int unsigned PARITY_BITS = 2;
  localparam int unsigned WORD_BITS   = DATA_BITS + PARITY_BITS;
  localparam logic [8:0]  LAST_CODE   = 9'h17f;

  // ****************************************
  // deadlines in word times
  // ****************************************
  localparam int unsigned SWITCH_LIMIT_WT = 8;
  localparam int unsigned ERR_LIMIT_WT    = 2;
  localparam logic [3:0]  WT_CNT_MAX      = 4'hf;

  // ****************************************
  // register port
  // ****************************************
  localparam int unsigned REG_AW      = 8;
  localparam logic [7:0]  OFF_LIVE    = 8'h00;
  localparam logic [7:0]  OFF_EVENT   = 8'h04;
  localparam logic [7:0]  OFF_CLEAR   = 8'h08;
  localparam logic [7:0]  OFF_ENABLE  = 8'h0c;
  localparam logic [7:0]  OFF_TRACK   = 8'h10;
  localparam int unsigned EV_W        = 5;
  localparam int unsigned EV_TRK_ERR  = 0;
  localparam int unsigned EV_OVERHEAT = 1;
  localparam int unsigned EV_SPEED    = 2;
  localparam int unsigned EV_PRESSURE = 3;
  localparam int unsigned EV_SWITCHED = 4;
  localparam logic [4:0]  EV_RESET    = 5'h00;
  localparam logic [4:0]  EN_RESET    = 5'h00;

  // ****************************************
  // track switch sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_CHECK = 2'b11
  } dtss_state_t;
endpackage

// [src/dtss_sel_if.sv]
// carrier between track sequencer and track decoder
`timescale 1ns/1ns
interface dtss_sel_if;
  logic [8:0]   addr;
  logic         load;
  logic [383:0] onehot;
  logic [8:0]   sel_count;

  modport dec (
    input  addr,
    input  load,
    output onehot,
    output sel_count
  );
  modport ctl (
    output addr,
    output load,
    input  onehot,
    input  sel_count
  );
endinterface

// [src/dtss_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dtss_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// [src/dtss_track_dec.sv]
// track address decoder with registered head select lines
`timescale 1ns/1ns
module dtss_track_dec #(
  parameter int unsigned N = dtss_pkg::N_TRACKS
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  dtss_sel_if.dec   sel
);
  logic [8:0] count_next;

  // codes at or above N decode to no head at all
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel.onehot <= '0;
    end else if (sel.load) begin
      for (int i = 0; i < 384; i++) begin
        sel.onehot[i] <= (i < N) && (sel.addr == 9'(i));
      end
    end
  end

  // counts real select lines, so a stuck or doubled line shows up
  always_comb begin
    count_next = 9'h000;
    for (int i = 0; i < 384; i++) begin
      count_next = count_next + {8'h00, sel.onehot[i]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel.sel_count <= 9'h000;
    end else begin
      sel.sel_count <= count_next;
    end
  end
endmodule

// [src/dtss_top.sv]
// drum track select and status logic, top level
`timescale 1ns/1ns
module dtss_top #(
  parameter int unsigned N_TRACKS = dtss_pkg::N_TRACKS
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         word_clk,
  input  wire logic [8:0]   track_addr,
  input  wire logic         overheat_sensor,
  input  wire logic         power_fault,
  input  wire logic         speed_fault,
  input  wire logic         pressure_fault,
  output logic              overheat_shutdown_line,
  output logic              power_error,
  output logic              speed_error,
  output logic              pressure_error,
  output logic              track_error,
  output logic [383:0]      track_select,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  output logic              irq
);
  // ****************************************
  // pin synchronisers and word clock edge
  // ****************************************
  logic [8:0] addr_s;
  logic [4:0] pins_s;
  logic       wclk_s;
  logic       over_s;
  logic       pwr_s;
  logic       spd_s;
  logic       prs_s;
  logic       wclk_d_reg;
  logic       word_tick;

  dtss_sync #(.W(9)) u_addr_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (track_addr),
    .q       (addr_s)
  );

  dtss_sync #(.W(5)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({word_clk, overheat_sensor, power_fault, speed_fault, pressure_fault}),
    .q       (pins_s)
  );

  assign wclk_s = pins_s[4];
  assign over_s = pins_s[3];
  assign pwr_s  = pins_s[2];
  assign spd_s  = pins_s[1];
  assign prs_s  = pins_s[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wclk_d_reg <= 1'b0;
    end else begin
      wclk_d_reg <= wclk_s;
    end
  end

  // leading edge of the word clock pulse is the one timing reference
  assign word_tick = wclk_s & ~wclk_d_reg;

  // ****************************************
  // track decoder
  // ****************************************
  dtss_sel_if sel ();

  dtss_track_dec #(.N(N_TRACKS)) u_dec (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sel     (sel.dec)
  );

  assign track_select = sel.onehot;

  // ****************************************
  // track switch sequencer
  // ****************************************
  dtss_pkg::dtss_state_t state_reg;
  dtss_pkg::dtss_state_t state_next;
  logic [8:0] held_addr_reg;
  logic       addr_changed;
  logic       load_pulse;
  logic       err_calc;
  logic       switched_pulse;
  logic [3:0] wt_cnt_reg;

  // the address is static while a track is used, so any difference is a switch
  assign addr_changed = (addr_s != held_addr_reg);
  assign load_pulse   = (state_reg == dtss_pkg::ST_LOAD) && word_tick;
  assign sel.addr     = held_addr_reg;
  assign sel.load     = load_pulse;

  // track n sits at code n-1; anything past the last track is refused
  assign err_calc = (held_addr_reg > dtss_pkg::LAST_CODE)
                  || (sel.sel_count != 9'h001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dtss_pkg::ST_IDLE: begin
        if (addr_changed) begin
          state_next = dtss_pkg::ST_LOAD;
        end
      end
      dtss_pkg::ST_LOAD: begin
        if (word_tick) begin
          state_next = dtss_pkg::ST_CHECK;
        end
      end
      dtss_pkg::ST_CHECK: begin
        if (addr_changed) begin
          state_next = dtss_pkg::ST_LOAD;
        end else if (word_tick) begin
          state_next = dtss_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = dtss_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= dtss_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // the head select follows the held code at the next word clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held_addr_reg <= 9'h000;
    // a change at the load tick waits for the restart, so decoder and held code agree
    end else if (addr_changed && !load_pulse) begin
      held_addr_reg <= addr_s;
    end
  end

  // reset leaves no head selected, which is itself a track error
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      track_error <= 1'b1;
    end else if ((state_reg == dtss_pkg::ST_CHECK) && word_tick && !addr_changed) begin
      track_error <= err_calc;
    end
  end

  assign switched_pulse = (state_reg == dtss_pkg::ST_CHECK) && word_tick && !addr_changed;

  // word times spent switching, for the deadline checks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wt_cnt_reg <= 4'h0;
    // a restart counts from the newest address
    end else if (state_reg == dtss_pkg::ST_IDLE || addr_changed) begin
      wt_cnt_reg <= 4'h0;
    end else if (word_tick && wt_cnt_reg != dtss_pkg::WT_CNT_MAX) begin
      wt_cnt_reg <= wt_cnt_reg + 4'h1;
    end
  end

  // ****************************************
  // environmental status lines
  // ****************************************
  // all lines are active high: 1 means the fault is present
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overheat_shutdown_line <= 1'b0;
      power_error            <= 1'b0;
      pressure_error         <= 1'b0;
    end else if (word_tick) begin
      overheat_shutdown_line <= over_s;
      power_error            <= pwr_s;
      pressure_error         <= prs_s;
    end
  end

  // once raised, only a cleared speed fault drops it, so it cannot chatter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speed_error <= 1'b0;
    end else if (word_tick) begin
      if (pwr_s && spd_s) begin
        speed_error <= 1'b1;
      end else if (!spd_s) begin
        speed_error <= 1'b0;
      end
    end
  end

  // ****************************************
  // events, interrupt and register port
  // ****************************************
  logic [4:0]  event_reg;
  logic [4:0]  enable_reg;
  logic [4:0]  live_d_reg;
  logic [4:0]  live;
  logic [4:0]  ev_in;
  logic [4:0]  clr;
  logic [31:0] rdata_next;

  assign live = {1'b0, pressure_error, speed_error, overheat_shutdown_line, track_error};
  assign ev_in = (live & ~live_d_reg) | {switched_pulse, 4'h0};
  assign clr = (reg_wr && reg_addr == dtss_pkg::OFF_CLEAR) ? reg_wdata[4:0] : 5'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // matches live at reset, so the reset track error is no false edge
      live_d_reg <= 5'h01;
    end else begin
      live_d_reg <= live;
    end
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_reg <= dtss_pkg::EV_RESET;
    end else begin
      event_reg <= (event_reg & ~clr) | ev_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_reg <= dtss_pkg::EN_RESET;
    end else if (reg_wr && reg_addr == dtss_pkg::OFF_ENABLE) begin
      enable_reg <= reg_wdata[4:0];
    end
  end

  assign irq = |(event_reg & enable_reg);

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      dtss_pkg::OFF_LIVE:   rdata_next = {27'h0, live};
      dtss_pkg::OFF_EVENT:  rdata_next = {27'h0, event_reg};
      dtss_pkg::OFF_ENABLE: rdata_next = {27'h0, enable_reg};
      dtss_pkg::OFF_TRACK:  rdata_next = {14'h0, sel.sel_count, held_addr_reg};
      default:              rdata_next = 32'h0000_0000;
    endcase
  end

  // unmapped and write-only addresses read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_load_step;
    (state_reg == dtss_pkg::ST_LOAD) && word_tick;
  endsequence

  sequence s_check_step;
    (state_reg == dtss_pkg::ST_CHECK) && word_tick && !addr_changed;
  endsequence

  property p_shutdown;
    @(posedge clk_sys) disable iff (rst)
      word_tick |=> (overheat_shutdown_line == $past(over_s));
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown line does not follow sensor");

  property p_speed_set;
    @(posedge clk_sys) disable iff (rst)
      (word_tick && pwr_s && spd_s) |=> speed_error;
  endproperty
  a_speed_set: assert property (p_speed_set)
    else $error("speed error not raised");

  property p_speed_hold;
    @(posedge clk_sys) disable iff (rst)
      (speed_error && spd_s) |=> speed_error;
  endproperty
  a_speed_hold: assert property (p_speed_hold)
    else $error("speed error dropped while fault present");

  property p_pressure;
    @(posedge clk_sys) disable iff (rst)
      word_tick |=> (pressure_error == $past(prs_s));
  endproperty
  a_pressure: assert property (p_pressure)
    else $error("pressure error does not follow fault");

  property p_select;
    @(posedge clk_sys) disable iff (rst)
      s_load_step |=> (held_addr_reg > dtss_pkg::LAST_CODE) ? (track_select == '0)
                      : $onehot(track_select) && track_select[held_addr_reg];
  endproperty
  a_select: assert property (p_select)
    else $error("wrong head selected");

  property p_switch_time;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == dtss_pkg::ST_LOAD) |-> (wt_cnt_reg < 4'd7);
  endproperty
  a_switch_time: assert property (p_switch_time)
    else $error("track switch too slow");

  property p_err_value;
    @(posedge clk_sys) disable iff (rst)
      s_load_step ##[1:100] s_check_step |=> (track_error == (held_addr_reg > dtss_pkg::LAST_CODE
                                       || !$onehot(track_select)));
  endproperty
  a_err_value: assert property (p_err_value)
    else $error("track error wrong after switch");

  property p_err_time;
    @(posedge clk_sys) disable iff (rst)
      s_check_step |-> (wt_cnt_reg < 4'd2);
  endproperty
  a_err_time: assert property (p_err_time)
    else $error("track error late");

  property p_on_tick;
    @(posedge clk_sys) disable iff (rst)
      ($changed(pressure_error) || $changed(overheat_shutdown_line)) |-> $past(word_tick);
  endproperty
  a_on_tick: assert property (p_on_tick)
    else $error("status changed off word clock");
endmodule

// [tb/dtss_ctrl_model.sv]
// drum controller side model: word clock source, track address holder, power cut
`timescale 1ns/1ns
module dtss_ctrl_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [8:0] req_addr,
  input  wire logic       overheat_shutdown_line,
  output logic            word_clk,
  output logic [8:0]      track_addr,
  output logic            ac_power_on
);
  // ****************************************
  // word time base
  // ****************************************
  logic [3:0] phase_reg;

  // free running, ten clocks a word time, high for three
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 4'h0;
      word_clk  <= 1'b0;
    end else begin
      phase_reg <= (phase_reg == 4'h9) ? 4'h0 : phase_reg + 4'h1;
      word_clk  <= (phase_reg < 4'h3);
    end
  end

  // ****************************************
  // track address and power
  // ****************************************
  // address moves only mid word time, then stays put for the whole access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      track_addr <= 9'h000;
    end else if (phase_reg == 4'h5) begin
      track_addr <= req_addr;
    end
  end

  // once power is cut it stays off until the next reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ac_power_on <= 1'b1;
    end else if (overheat_shutdown_line) begin
      ac_power_on <= 1'b0;
    end
  end
endmodule

// [tb/test_dtss_top.sv]
// self-checking bench for the drum track select and status block
`timescale 1ns/1ns
module test_dtss_top;
  logic         clk_sys;
  logic         rst;
  logic         word_clk;
  logic [8:0]   track_addr;
  logic [8:0]   req_addr;
  logic         overheat_sensor;
  logic         power_fault;
  logic         speed_fault;
  logic         pressure_fault;
  logic         overheat_shutdown_line;
  logic         power_error;
  logic         speed_error;
  logic         pressure_error;
  logic         track_error;
  logic [383:0] track_select;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic         irq;
  logic         ac_power_on;
  logic         rd_d;
  logic [31:0]  rd_q[$];
  logic [8:0]   codes[5];
  int           fail_count;
  int           checks;

  dtss_top dtss_top_inst (
    .clk_sys(clk_sys), .rst(rst), .word_clk(word_clk), .track_addr(track_addr),
    .overheat_sensor(overheat_sensor), .power_fault(power_fault),
    .speed_fault(speed_fault), .pressure_fault(pressure_fault),
    .overheat_shutdown_line(overheat_shutdown_line), .power_error(power_error),
    .speed_error(speed_error), .pressure_error(pressure_error),
    .track_error(track_error), .track_select(track_select), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  dtss_ctrl_model dtss_ctrl_model_inst (
    .clk_sys(clk_sys), .rst(rst), .req_addr(req_addr),
    .overheat_shutdown_line(overheat_shutdown_line), .word_clk(word_clk),
    .track_addr(track_addr), .ac_power_on(ac_power_on)
  );

  // ****************************************
  // clock, reset, watchdog
  // ****************************************
  initial begin
    clk_sys         = 1'b0;
    rst             = 1'b1;
    req_addr        = 9'h000;
    overheat_sensor = 1'b0;
    power_fault     = 1'b0;
    speed_fault     = 1'b0;
    pressure_fault  = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    fail_count      = 0;
    checks          = 0;
  end

  always #5 clk_sys = ~clk_sys;

  // whole run needs under a thousand cycles; ten times that means a hang
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    summarize();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [383:0] got, input logic [383:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t read got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // idle edge: back-to-back calls never drive a strobe twice in one step
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge word_clk);
    repeat (5) @(posedge clk_sys);
  endtask

  // change of track, judged five clocks after the third word clock pulse
  task automatic go_track(input logic [8:0] code);
    logic ok;
    ok = (code < 9'h180);
    req_addr <= code;
    settle(3);
    cmp(track_select, ok ? (384'h1 << code) : 384'h0, "select");
    cmp(track_error, !ok, "track error");
    rd(dtss_pkg::OFF_TRACK, {14'h0, ok ? 9'h001 : 9'h000, code});
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      cmp_rd(reg_rdata, rd_q.pop_front());
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    codes = '{9'h005, 9'h000, 9'h17f, 9'h180, 9'h1ff};
    void'($urandom(50486));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp(track_error, 1'b1, "reset track error");
    cmp(track_select, 384'h0, "reset select");
    cmp(irq, 1'b0, "reset irq");
    rd(dtss_pkg::OFF_EVENT, 32'h0);
    rd(dtss_pkg::OFF_ENABLE, 32'h0);
    $display("test reset done");

    foreach (codes[i]) begin
      go_track(codes[i]);
    end
    repeat (4) begin
      go_track(9'($urandom % 384));
    end
    $display("test track done");

    speed_fault <= 1'b1;
    settle(2);
    cmp(speed_error, 1'b0, "speed without power error");
    power_fault <= 1'b1;
    settle(2);
    cmp(power_error, 1'b1, "power error");
    cmp(speed_error, 1'b1, "speed error");
    power_fault <= 1'b0;
    settle(3);
    cmp(speed_error, 1'b1, "speed error held");
    speed_fault <= 1'b0;
    settle(2);
    cmp(speed_error, 1'b0, "speed clear");
    $display("test speed done");

    go_track(9'h007);
    wr(dtss_pkg::OFF_CLEAR, 32'h1f);
    wr(dtss_pkg::OFF_ENABLE, 32'h02);
    rd(dtss_pkg::OFF_ENABLE, 32'h2);
    overheat_sensor <= 1'b1;
    settle(2);
    cmp(overheat_shutdown_line, 1'b1, "shutdown");
    cmp(ac_power_on, 1'b0, "power cut");
    cmp(irq, 1'b1, "irq raised");
    rd(dtss_pkg::OFF_EVENT, 32'h2);
    rd(dtss_pkg::OFF_LIVE, 32'h2);
    wr(dtss_pkg::OFF_LIVE, 32'hff);
    rd(dtss_pkg::OFF_LIVE, 32'h2);
    rd(8'h20, 32'h0);
    overheat_sensor <= 1'b0;
    settle(2);
    cmp(overheat_shutdown_line, 1'b0, "shutdown clears");
    wr(dtss_pkg::OFF_CLEAR, 32'h2);
    @(posedge clk_sys);
    cmp(irq, 1'b0, "irq cleared");
    rd(dtss_pkg::OFF_EVENT, 32'h0);
    wr(dtss_pkg::OFF_ENABLE, 32'h0);
    pressure_fault <= 1'b1;
    settle(2);
    cmp(pressure_error, 1'b1, "pressure");
    cmp(irq, 1'b0, "irq masked");
    rd(dtss_pkg::OFF_EVENT, 32'h8);
    pressure_fault <= 1'b0;
    settle(2);
    cmp(pressure_error, 1'b0, "pressure clears");
    $display("test status and irq done");

    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule
